/* rtl/iab_pkg.sv */
package iab_pkg;

  // Register map: arithmetic controls word
  localparam logic [11:0] IAB_AC_OFFSET    = 12'h000;
  localparam int          IAB_CC_LSB       = 0;
  localparam int          IAB_CC_WIDTH     = 3;
  localparam int          IAB_OVF_FLAG_BIT = 8;
  localparam int          IAB_OVF_MASK_BIT = 12;
  localparam logic [2:0]  IAB_CC_RESET     = 3'h0;
  localparam logic        IAB_OVF_FLAG_RST = 1'b0;
  localparam logic        IAB_OVF_MASK_RST = 1'b0;

  // Condition-code meanings used by the bit and carry operations
  localparam logic [2:0]  IAB_CC_TRUE      = 3'h2;
  localparam logic [2:0]  IAB_CC_FALSE     = 3'h0;
  localparam int          IAB_CARRY_BIT    = 1;
  localparam int          IAB_VOVF_BIT     = 0;

  // Operation select from the instruction decoder
  typedef enum logic [5:0] {
    IAB_ADD_ORD, IAB_ADD_INT, IAB_ADD_ORD_CND, IAB_ADD_INT_CND,
    IAB_SUB_ORD, IAB_SUB_INT, IAB_SUB_ORD_CND, IAB_SUB_INT_CND,
    IAB_MUL_ORD, IAB_MUL_INT, IAB_DIV_ORD, IAB_DIV_INT,
    IAB_REM_ORD, IAB_REM_INT, IAB_MOD_INT,
    IAB_SHL_ORD, IAB_SHR_ORD, IAB_SHL_INT, IAB_SHR_INT, IAB_SHR_DIV,
    IAB_ROT_LEFT, IAB_SHR_EXT,
    IAB_ADD_CARRY, IAB_SUB_CARRY, IAB_MUL_EXT, IAB_DIV_EXT,
    IAB_LG_AND, IAB_LG_NOTAND, IAB_LG_ANDNOT, IAB_LG_XOR, IAB_LG_OR,
    IAB_LG_NOR, IAB_LG_XNOR, IAB_LG_NOT, IAB_LG_NOTOR, IAB_LG_ORNOT,
    IAB_LG_NAND,
    IAB_BIT_SET, IAB_BIT_CLR, IAB_BIT_INV, IAB_BIT_ALTER,
    IAB_BIT_SCAN, IAB_BIT_SPAN, IAB_FLD_EXTRACT, IAB_FLD_MODIFY
  } iab_op_t;

  // Whole state of the unit
  typedef struct packed {
    logic [2:0]  cc;
    logic        ovfFlag;
    logic        ovfMask;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        resValid;
    logic        resWrite;
    logic        resPair;
    logic [31:0] resLo;
    logic [31:0] resHi;
    logic        faultIntOvf;
    logic        faultZeroDiv;
  } iab_state_t;

endpackage

/* rtl/iab_alu.sv */
`timescale 1ns/1ps
`default_nettype none

module iab_alu #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire  logic             core_clk,
  input  wire  logic             sys_rst,
  // APB slave
  input  wire  logic             psel,
  input  wire  logic             penable,
  input  wire  logic             pwrite,
  input  wire  logic [ADDR_W-1:0] paddr,
  input  wire  logic [31:0]      pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Operation request from decode and register file
  input  wire  logic             opValid,
  input  wire  iab_pkg::iab_op_t opCode,
  input  wire  logic             condPass,
  input  wire  logic [31:0]      src1Reg,
  input  wire  logic [31:0]      src2Reg,
  input  wire  logic [31:0]      src3Reg,
  input  wire  logic             src1IsLit,
  input  wire  logic             src2IsLit,
  input  wire  logic [4:0]       lit1,
  input  wire  logic [4:0]       lit2,
  // Result toward the register file and fault logic
  output logic                   resValid,
  output logic                   resWrite,
  output logic                   resPair,
  output logic [31:0]            resLo,
  output logic [31:0]            resHi,
  output logic                   faultIntOvf,
  output logic                   faultZeroDiv,
  output logic [2:0]             acCc
);
  import iab_pkg::*;

  // Elaboration check on the address width
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_chk
    $error("iab_alu: ADDR_W must lie in 3..32");
  end

  // Packs the arithmetic controls word
  function automatic logic [31:0] acWord(input logic [2:0] c, input logic f, input logic m);
    logic [31:0] w;
    w = 32'h0;
    w[IAB_CC_LSB +: IAB_CC_WIDTH] = c;
    w[IAB_OVF_FLAG_BIT] = f;
    w[IAB_OVF_MASK_BIT] = m;
    return w;
  endfunction

  // Signed left shift by the largest count up to n that keeps the value
  function automatic logic [31:0] shlSat(input logic [31:0] v, input logic [5:0] n);
    logic [31:0] r;
    logic [31:0] t;
    r = v;
    for (int k = 1; k < 32; k++) begin
      t = v << k;
      if (6'(k) <= n && ($signed(t) >>> k) == $signed(v)) begin
        r = t;
      end
    end
    return r;
  endfunction

  // Finds the highest set bit; bit 5 of the answer marks a hit
  function automatic logic [5:0] topOne(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  iab_state_t st;
  iab_state_t next_st;

  logic [31:0] x;
  logic [31:0] y;
  logic [32:0] sum33;
  logic [63:0] prodU;
  logic [63:0] prodS;
  logic [63:0] pair64;
  logic [63:0] shr64;
  logic [63:0] ediv64;
  logic [31:0] quotS;
  logic [31:0] remS;
  logic [31:0] bitMask;
  logic [31:0] lenMask;
  logic [31:0] lostMask;
  logic [31:0] exactShl;
  logic [5:0]  shlCount;
  logic [5:0]  found;
  logic        bigCount;
  logic        yZero;
  logic        ovfEv;
  logic        zdivEv;
  logic        apbHit;
  logic        apbWr;

  // Operand select: register or zero-extended literal
  assign x = src2IsLit ? {27'h0, lit2} : src2Reg;
  assign y = src1IsLit ? {27'h0, lit1} : src1Reg;

  // APB decode and write strobe at the completing edge
  assign apbHit = paddr[ADDR_W-1:2] == (ADDR_W-2)'(IAB_AC_OFFSET[11:2]);
  assign apbWr  = psel && penable && st.pready && pwrite && apbHit;

  // Next-state logic: bus, then operation
  always_comb begin
    next_st   = st;
    sum33     = 33'h0;
    prodU     = 64'({32'h0, x}) * 64'({32'h0, y});
    prodS     = 64'($signed({{32{x[31]}}, x}) * $signed({{32{y[31]}}, y}));
    pair64    = {src3Reg, x};
    shr64     = pair64 >> y[5:0];
    yZero     = y == 32'h0;
    ediv64    = yZero ? 64'h0 : pair64 / {32'h0, y};
    // One extra bit keeps the most negative value over minus one from trapping
    quotS     = yZero ? 32'h0 : 32'($signed({x[31], x}) / $signed({y[31], y}));
    remS      = yZero ? 32'h0 : 32'($signed({x[31], x}) % $signed({y[31], y}));
    bitMask   = 32'h1 << y[4:0];
    lenMask   = (|x[31:5]) ? 32'hFFFFFFFF : (32'h1 << x[4:0]) - 32'h1;
    bigCount  = |y[31:5];
    lostMask  = bigCount ? 32'hFFFFFFFF : bitMask - 32'h1;
    exactShl  = bigCount ? 32'h0 : x << y[4:0];
    shlCount  = bigCount ? 6'h20 : {1'b0, y[4:0]};
    found     = topOne(x);
    ovfEv     = 1'b0;
    zdivEv    = 1'b0;

    // APB: answer one cycle after setup
    next_st.pready  = psel && !penable;
    next_st.pslverr = psel && !penable && !apbHit;
    next_st.prdata  = (psel && !penable && !pwrite && apbHit) ?
                      acWord(st.cc, st.ovfFlag, st.ovfMask) : 32'h0;
    if (apbWr) begin
      next_st.cc      = pwdata[IAB_CC_LSB +: IAB_CC_WIDTH];
      next_st.ovfFlag = pwdata[IAB_OVF_FLAG_BIT];
      next_st.ovfMask = pwdata[IAB_OVF_MASK_BIT];
    end

    // Result valid and write follow opValid; pair, high word and fault pulses default off
    next_st.resValid     = opValid;
    next_st.resWrite     = opValid;
    next_st.resPair      = 1'b0;
    next_st.resHi        = 32'h0;
    next_st.faultIntOvf  = 1'b0;
    next_st.faultZeroDiv = 1'b0;

    unique case (opCode)
      IAB_ADD_ORD, IAB_ADD_ORD_CND, IAB_ADD_INT, IAB_ADD_INT_CND: begin
        next_st.resLo = x + y;
        if (opCode == IAB_ADD_INT || opCode == IAB_ADD_INT_CND) begin
          ovfEv = (x[31] == y[31]) && (next_st.resLo[31] != x[31]);
        end
      end
      IAB_SUB_ORD, IAB_SUB_ORD_CND, IAB_SUB_INT, IAB_SUB_INT_CND: begin
        next_st.resLo = x - y;
        if (opCode == IAB_SUB_INT || opCode == IAB_SUB_INT_CND) begin
          ovfEv = (x[31] != y[31]) && (next_st.resLo[31] != x[31]);
        end
      end
      IAB_MUL_ORD: next_st.resLo = prodU[31:0];
      IAB_MUL_INT: begin
        next_st.resLo = prodS[31:0];
        ovfEv = prodS[63:32] != {32{prodS[31]}};
      end
      IAB_DIV_ORD: begin
        next_st.resLo = yZero ? 32'h0 : x / y;
        zdivEv = yZero;
      end
      IAB_DIV_INT: begin
        next_st.resLo = quotS;
        zdivEv = yZero;
        ovfEv  = !yZero && x == 32'h80000000 && y == 32'hFFFFFFFF;
      end
      IAB_REM_ORD: begin
        next_st.resLo = yZero ? 32'h0 : x % y;
        zdivEv = yZero;
      end
      IAB_REM_INT: begin
        next_st.resLo = remS;
        zdivEv = yZero;
      end
      IAB_MOD_INT: begin
        // Shift a nonzero remainder onto the divisor's side of zero
        next_st.resLo = (remS != 32'h0 && remS[31] != y[31]) ? remS + y : remS;
        zdivEv = yZero;
      end
      IAB_SHL_ORD: next_st.resLo = exactShl;
      IAB_SHR_ORD: next_st.resLo = bigCount ? 32'h0 : x >> y[4:0];
      IAB_SHL_INT: begin
        next_st.resLo = shlSat(x, shlCount);
        ovfEv = next_st.resLo != exactShl;
      end
      IAB_SHR_INT: begin
        next_st.resLo = bigCount ? {32{x[31]}} : 32'($signed(x) >>> y[4:0]);
      end
      IAB_SHR_DIV: begin
        next_st.resLo = (bigCount ? {32{x[31]}} : 32'($signed(x) >>> y[4:0]))
                        + {31'h0, x[31] && |(x & lostMask)};
      end
      IAB_ROT_LEFT: next_st.resLo = (x << y[4:0]) | (x >> (6'h20 - {1'b0, y[4:0]}));
      IAB_SHR_EXT: next_st.resLo = shr64[31:0];
      IAB_ADD_CARRY, IAB_SUB_CARRY: begin
        if (opCode == IAB_ADD_CARRY) begin
          sum33 = {1'b0, x} + {1'b0, y} + {32'h0, st.cc[IAB_CARRY_BIT]};
          next_st.cc[IAB_VOVF_BIT] = (x[31] == y[31]) && (sum33[31] != x[31]);
        end else begin
          sum33 = {1'b0, x} + {1'b0, ~y} + {32'h0, st.cc[IAB_CARRY_BIT]};
          next_st.cc[IAB_VOVF_BIT] = (x[31] != y[31]) && (sum33[31] != x[31]);
        end
        next_st.resLo = sum33[31:0];
        next_st.cc[IAB_CARRY_BIT] = sum33[32];
        next_st.cc[2] = 1'b0;
      end
      IAB_MUL_EXT: begin
        next_st.resLo   = prodU[31:0];
        next_st.resHi   = prodU[63:32];
        next_st.resPair = 1'b1;
      end
      IAB_DIV_EXT: begin
        next_st.resLo   = yZero ? 32'h0 : 32'(pair64 - 64'(ediv64 * {32'h0, y}));
        next_st.resHi   = ediv64[31:0];
        next_st.resPair = 1'b1;
        zdivEv = yZero;
      end
      IAB_LG_AND:    next_st.resLo = x & y;
      IAB_LG_NOTAND: next_st.resLo = ~x & y;
      IAB_LG_ANDNOT: next_st.resLo = x & ~y;
      IAB_LG_XOR:    next_st.resLo = x ^ y;
      IAB_LG_OR:     next_st.resLo = x | y;
      IAB_LG_NOR:    next_st.resLo = ~(x | y);
      IAB_LG_XNOR:   next_st.resLo = ~(x ^ y);
      IAB_LG_NOT:    next_st.resLo = ~y;
      IAB_LG_NOTOR:  next_st.resLo = ~x | y;
      IAB_LG_ORNOT:  next_st.resLo = x | ~y;
      IAB_LG_NAND:   next_st.resLo = ~(x & y);
      IAB_BIT_SET:   next_st.resLo = x | bitMask;
      IAB_BIT_CLR:   next_st.resLo = x & ~bitMask;
      IAB_BIT_INV:   next_st.resLo = x ^ bitMask;
      IAB_BIT_ALTER: begin
        // Codes other than the two defined ones follow cc bit 1
        next_st.resLo = st.cc[1] ? (x | bitMask) : (x & ~bitMask);
      end
      IAB_BIT_SCAN, IAB_BIT_SPAN: begin
        found = topOne(opCode == IAB_BIT_SCAN ? y : ~y);
        next_st.resLo = found[5] ? {27'h0, found[4:0]} : 32'hFFFFFFFF;
        next_st.cc    = found[5] ? IAB_CC_TRUE : IAB_CC_FALSE;
      end
      IAB_FLD_EXTRACT: next_st.resLo = (src3Reg >> y[4:0]) & lenMask;
      IAB_FLD_MODIFY:  next_st.resLo = (x & y) | (src3Reg & ~y);
      default:         next_st.resLo = 32'h0;
    endcase

    // A conditional form whose condition failed writes nothing and keeps resLo and cc
    if (!opValid || ((opCode == IAB_ADD_ORD_CND || opCode == IAB_ADD_INT_CND ||
                      opCode == IAB_SUB_ORD_CND || opCode == IAB_SUB_INT_CND) && !condPass)) begin
      next_st.resWrite = 1'b0;
      next_st.resLo    = st.resLo;
      next_st.resPair  = 1'b0;
      ovfEv            = 1'b0;
      zdivEv           = 1'b0;
      if (!opValid || apbWr) begin
        next_st.cc = apbWr ? pwdata[IAB_CC_LSB +: IAB_CC_WIDTH] : st.cc;
      end
    end

    // Fault or sticky flag; a hardware set beats a bus clear
    if (ovfEv) begin
      if (st.ovfMask) begin
        next_st.ovfFlag = 1'b1;
      end else begin
        next_st.faultIntOvf = 1'b1;
      end
    end
    if (zdivEv) begin
      next_st.faultZeroDiv = 1'b1;
      next_st.resWrite     = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st         <= '0;
      st.cc      <= IAB_CC_RESET;
      st.ovfFlag <= IAB_OVF_FLAG_RST;
      st.ovfMask <= IAB_OVF_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign resValid     = st.resValid;
  assign resWrite     = st.resWrite;
  assign resPair      = st.resPair;
  assign resLo        = st.resLo;
  assign resHi        = st.resHi;
  assign faultIntOvf  = st.faultIntOvf;
  assign faultZeroDiv = st.faultZeroDiv;
  assign acCc         = st.cc;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_apb_answer;
    pready ##1 !pready;
  endsequence

  a_apb_ready_once: assert property (s_apb_setup |=> s_apb_answer)
    else $error("APB ready not a single cycle after setup");
  a_zero_div_fault: assert property (opValid && yZero &&
      (opCode == IAB_DIV_ORD || opCode == IAB_DIV_INT) |=> faultZeroDiv && resValid && !resWrite)
    else $error("zero divisor did not fault");
  a_ovf_fault_path: assert property (opValid && opCode == IAB_ADD_INT &&
      !st.ovfMask && x == 32'h7FFFFFFF && y != 32'h0 && !y[31] |=> faultIntOvf)
    else $error("signed add overflow not faulted");
  a_ovf_sticky_flag: assert property (opValid && opCode == IAB_MUL_INT &&
      st.ovfMask && prodS[63:32] != {32{prodS[31]}} |=> !faultIntOvf && st.ovfFlag)
    else $error("masked overflow did not set sticky flag");
  a_rem_sign: assert property (opValid && opCode == IAB_REM_INT && !yZero |=>
      resLo == 32'h0 || resLo[31] == $past(x[31]))
    else $error("remainder sign differs from dividend");
  a_mod_sign: assert property (opValid && opCode == IAB_MOD_INT && !yZero |=>
      resLo == 32'h0 || resLo[31] == $past(y[31]))
    else $error("modulo sign differs from divisor");
  a_shr_zero_fill: assert property (opValid && opCode == IAB_SHR_ORD && y == 32'h1 |=>
      !resLo[31] && resLo[30:0] == $past(x[31:1]))
    else $error("unsigned right shift fill wrong");
  a_shrdi_round: assert property (opValid && opCode == IAB_SHR_DIV &&
      x == 32'hFFFFFFFF && y == 32'h1 |=> resLo == 32'h0)
    else $error("dividing shift of minus one not zero");
  a_carry_chain: assert property (opValid && opCode == IAB_ADD_CARRY &&
      x == 32'hFFFFFFFF && y == 32'h0 && st.cc[1] |=> (acCc[1] && resLo == 32'h0) ##1
      (acCc[1] || $past(opValid) || $past(apbWr)))
    else $error("carry out not captured in cc bit 1");
  a_scan_none: assert property (opValid && opCode == IAB_BIT_SCAN && y == 32'h0 |=>
      resLo == 32'hFFFFFFFF && acCc == IAB_CC_FALSE)
    else $error("scan of zero wrong");
  a_modify_keep: assert property (opValid && opCode == IAB_FLD_MODIFY |=>
      (resLo & ~$past(y)) == ($past(src3Reg) & ~$past(y)))
    else $error("modify touched unmasked bits");

endmodule // iab_alu

`default_nettype wire

/* dv/iab_rf_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Decode and register-file side: one operation request per call
module iab_rf_model (
  // Clock
  input  wire logic             core_clk,
  // Operation request
  output var  logic             opValid,
  output var  iab_pkg::iab_op_t opCode,
  output var  logic             condPass,
  output var  logic [31:0]      src1Reg,
  output var  logic [31:0]      src2Reg,
  output var  logic [31:0]      src3Reg,
  output var  logic             src1IsLit,
  output var  logic             src2IsLit,
  output var  logic [4:0]       lit1,
  output var  logic [4:0]       lit2
);
  import iab_pkg::*;
  // Quiet request lines at start
  initial begin
    opValid = 1'b0;
    {condPass, src1IsLit, src2IsLit} = '0;
    {src1Reg, src2Reg, src3Reg, lit1, lit2} = '0;
    opCode = IAB_ADD_ORD;
  end
  // Small operands go as literals at random; the unused register holds the operand's complement
  task automatic issue(input iab_op_t op, input logic cp,
                       input logic [31:0] x, y, z);
    logic l1, l2;
    l1 = (y < 32) && ($urandom_range(1) == 1);
    l2 = (x < 32) && ($urandom_range(1) == 1);
    @(posedge core_clk);
    opValid   <= 1'b1;
    opCode    <= op;
    condPass  <= cp;
    src1IsLit <= l1;
    src2IsLit <= l2;
    src1Reg   <= l1 ? ~y : y;
    src2Reg   <= l2 ? ~x : x;
    src3Reg   <= z;
    lit1      <= y[4:0];
    lit2      <= x[4:0];
  endtask
  // Drop the request after a burst
  task automatic idle();
    @(posedge core_clk);
    opValid <= 1'b0;
  endtask
endmodule // iab_rf_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the integer unit
module tb_top;
  import iab_pkg::*;
  typedef struct {
    logic        w, pr, ov, zd;
    logic [31:0] lo, hi;
    logic [2:0]  cc;
  } iab_exp_t;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        resValid, resWrite, resPair, faultIntOvf, faultZeroDiv;
  logic        opValid, condPass, src1IsLit, src2IsLit, flag, mask;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, resLo, resHi, src1Reg, src2Reg, src3Reg;
  logic [4:0]  lit1, lit2;
  logic [2:0]  acCc, cc;
  logic [32:0] aq[$], ap;
  iab_op_t     opCode, o;
  iab_exp_t    eq[$], got;
  int          n_errors, compares, cyc;
  iab_op_t     cOp[16] = '{IAB_DIV_INT, IAB_DIV_ORD, IAB_ADD_INT, IAB_SUB_INT,
    IAB_MUL_INT, IAB_SHL_INT, IAB_SHR_DIV, IAB_SHR_INT, IAB_BIT_SCAN, IAB_BIT_SPAN,
    IAB_MOD_INT, IAB_REM_INT, IAB_SHR_EXT, IAB_ADD_CARRY, IAB_DIV_EXT, IAB_ROT_LEFT};
  logic [31:0] cX[16] = '{32'h80000000, 32'h5, 32'h7FFFFFFF, 32'h80000000,
    32'h10000, 32'h40000001, 32'hFFFFFFF9, 32'hFFFFFFF9, 32'h0, 32'h0,
    32'hFFFFFFF9, 32'hFFFFFFF9, 32'h1, 32'hFFFFFFFF, 32'h8, 32'h80000001};
  logic [31:0] cY[16] = '{32'hFFFFFFFF, 32'h0, 32'h1, 32'h1, 32'h10000, 32'h3,
    32'h2, 32'h2, 32'h0, 32'hFFFFFFFF, 32'h2, 32'h2, 32'h20, 32'h1, 32'h0, 32'h1};

  iab_alu #(.ADDR_W(12)) DUT (.core_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .opValid, .opCode, .condPass,
    .src1Reg, .src2Reg, .src3Reg, .src1IsLit, .src2IsLit, .lit1, .lit2,
    .resValid, .resWrite, .resPair, .resLo, .resHi, .faultIntOvf,
    .faultZeroDiv, .acCc);
  iab_rf_model u_rf (.core_clk, .opValid, .opCode, .condPass, .src1Reg,
    .src2Reg, .src3Reg, .src1IsLit, .src2IsLit, .lit1, .lit2);

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Compare one value
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts and verdict
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Expected answer of one operation; tracks cc and the sticky flag
  function automatic iab_exp_t model(iab_op_t c, logic cp, logic [31:0] x, y, z);
    iab_exp_t e;
    logic [63:0] p;
    logic signed [63:0] sp;
    logic [32:0] s;
    logic [31:0] t;
    int k;
    e = '{1'b1, 1'b0, 1'b0, 1'b0, '0, '0, cc};
    case (c)
      IAB_ADD_ORD, IAB_ADD_ORD_CND, IAB_ADD_INT, IAB_ADD_INT_CND: begin
        e.lo = x + y;
        e.ov = (x[31] == y[31]) && (e.lo[31] != x[31]);
      end
      IAB_SUB_ORD, IAB_SUB_ORD_CND, IAB_SUB_INT, IAB_SUB_INT_CND: begin
        e.lo = x - y;
        e.ov = (x[31] != y[31]) && (e.lo[31] != x[31]);
      end
      IAB_MUL_ORD, IAB_MUL_INT, IAB_DIV_INT, IAB_REM_INT, IAB_MOD_INT: begin
        if (c == IAB_DIV_INT) sp = $signed(x) / $signed(y);
        else if (c == IAB_MUL_ORD || c == IAB_MUL_INT) sp = $signed(x) * $signed(y);
        else sp = $signed(x) % $signed(y);
        if (c == IAB_MOD_INT && sp != 0 && sp[63] != y[31]) sp = sp + $signed(y);
        e.lo = sp[31:0];
        e.ov = sp != {{32{sp[31]}}, sp[31:0]};
      end
      IAB_DIV_ORD:   e.lo = x / y;
      IAB_REM_ORD:   e.lo = x % y;
      IAB_SHL_ORD:   e.lo = (y > 31) ? '0 : x << y;
      IAB_SHR_ORD:   e.lo = (y > 31) ? '0 : x >> y;
      IAB_SHR_INT, IAB_SHR_DIV: begin
        e.lo = $signed(x) >>> ((y > 31) ? 31 : y);
        if (c == IAB_SHR_DIV && x[31] && (y > 31 || (x << (32 - y)) != 0))
          e.lo = e.lo + 1;
      end
      IAB_SHL_INT: begin
        k = (y > 31) ? 32 : y;
        while (k > 0 && ($signed(x << k) >>> k) != $signed(x)) k--;
        e.lo = x << k;
        e.ov = k != ((y > 31) ? 32 : y);
      end
      IAB_ROT_LEFT: begin
        p = {x, x} << y[4:0];
        e.lo = p[63:32];
      end
      IAB_SHR_EXT: begin
        p = {z, x} >> y[5:0];
        e.lo = p[31:0];
      end
      IAB_ADD_CARRY, IAB_SUB_CARRY: begin
        t = (c == IAB_ADD_CARRY) ? y : ~y;
        s = x + t + cc[1];
        e.lo = s[31:0];
        e.cc = {1'b0, s[32], (x[31] == t[31]) && (s[31] != x[31])};
      end
      IAB_MUL_EXT: begin
        p = x * y;
        {e.hi, e.lo, e.pr} = {p, 1'b1};
      end
      IAB_DIV_EXT: begin
        p = {z, x} / y;
        e.hi = p[31:0];
        p = {z, x} % y;
        {e.lo, e.pr} = {p[31:0], 1'b1};
      end
      IAB_LG_AND:    e.lo = x & y;
      IAB_LG_NOTAND: e.lo = ~x & y;
      IAB_LG_ANDNOT: e.lo = x & ~y;
      IAB_LG_XOR:    e.lo = x ^ y;
      IAB_LG_OR:     e.lo = x | y;
      IAB_LG_NOR:    e.lo = ~(x | y);
      IAB_LG_XNOR:   e.lo = ~(x ^ y);
      IAB_LG_NOT:    e.lo = ~y;
      IAB_LG_NOTOR:  e.lo = ~x | y;
      IAB_LG_ORNOT:  e.lo = x | ~y;
      IAB_LG_NAND:   e.lo = ~(x & y);
      IAB_BIT_SET:   e.lo = x | (32'h1 << y[4:0]);
      IAB_BIT_CLR:   e.lo = x & ~(32'h1 << y[4:0]);
      IAB_BIT_INV:   e.lo = x ^ (32'h1 << y[4:0]);
      IAB_BIT_ALTER: e.lo = (x & ~(32'h1 << y[4:0])) | ({31'h0, cc[1]} << y[4:0]);
      IAB_BIT_SCAN, IAB_BIT_SPAN: begin
        e.lo = '1;
        e.cc = IAB_CC_FALSE;
        for (k = 0; k < 32; k++) begin
          if (y[k] == (c == IAB_BIT_SCAN)) {e.lo, e.cc} = {k[31:0], IAB_CC_TRUE};
        end
      end
      IAB_FLD_EXTRACT:
        e.lo = (z >> y[4:0]) & ((x > 31) ? 32'hFFFFFFFF : ~(32'hFFFFFFFF << x));
      default:       e.lo = (x & y) | (z & ~y);
    endcase
    if (!(c inside {IAB_ADD_INT, IAB_ADD_INT_CND, IAB_SUB_INT, IAB_SUB_INT_CND,
                    IAB_MUL_INT, IAB_DIV_INT, IAB_SHL_INT})) e.ov = 1'b0;
    e.zd = (y == 0) && (c inside {IAB_DIV_ORD, IAB_DIV_INT, IAB_REM_ORD,
                                  IAB_REM_INT, IAB_MOD_INT, IAB_DIV_EXT});
    if (e.zd || (!cp && c inside {IAB_ADD_ORD_CND, IAB_ADD_INT_CND, IAB_SUB_ORD_CND,
                                  IAB_SUB_INT_CND})) {e.w, e.ov, e.cc} = {2'b00, cc};
    if (e.ov && mask) {flag, e.ov} = 2'b10;
    cc = e.cc;
    return e;
  endfunction
  // Note the answer, then hand the request to the decode side
  task automatic op(iab_op_t c, logic cp, logic [31:0] x, y, z);
    eq.push_back(model(c, cp, x, y, z));
    u_rf.issue(c, cp, x, y, z);
  endtask
  // One APB transfer; the expected answer is noted first
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    if (a[11:2] != 0) aq.push_back({1'b1, 32'h0});
    else if (wr) aq.push_back(33'h0);
    else aq.push_back({20'h0, mask, 3'h0, flag, 5'h0, cc});
    if (a[11:2] == 0 && wr) {mask, flag, cc} = {d[12], d[8], d[2:0]};
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  // Answer watcher: the oldest note against each answer
  always @(negedge core_clk) begin
    if (resValid === 1'b1 && eq.size() == 0) chk("spare result", 0, 1);
    else if (resValid === 1'b1) begin
      got = eq.pop_front();
      chk("resWrite", got.w, resWrite);
      if (got.w) chk("resLo", got.lo, resLo);
      if (got.w) chk("resPair", got.pr, resPair);
      if (got.w && got.pr) chk("resHi", got.hi, resHi);
      chk("faultIntOvf", got.ov, faultIntOvf);
      chk("faultZeroDiv", got.zd, faultZeroDiv);
      chk("acCc", got.cc, acCc);
    end
    if (pready === 1'b1 && aq.size() == 0) chk("spare ready", 0, 1);
    else if (pready === 1'b1) begin
      ap = aq.pop_front();
      chk("pslverr", ap[32], pslverr);
      chk("prdata", ap[31:0], prdata);
    end
  end
  // Hang guard
  initial begin
    cyc = 0;
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 5000) begin
        n_errors++;
        wrap_up();
      end
    end
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cc, flag, mask} = '0;
    n_errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    void'($urandom(89972));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    apb(1'b0, 12'h008, 32'h0);
    $display("Test registers done");
    for (int i = 0; i < 16; i++) op(cOp[i], 1'b1, cX[i], cY[i], $urandom);
    $display("Test corners done");
    o = o.first();
    do begin
      repeat (6) op(o, 1'b1, ($urandom_range(3) == 0) ? $urandom_range(31) : $urandom,
        ($urandom_range(1) == 1) ? $urandom : $urandom_range(40), $urandom);
      o = o.next();
    end while (o != o.first());
    $display("Test all operations done");
    foreach (cOp[i]) op(iab_op_t'(i % 8), i[3], $urandom, $urandom, 32'h0);
    u_rf.idle();
    $display("Test conditional done");
    apb(1'b1, 12'h000, 32'h00001000);
    op(IAB_ADD_INT, 1'b1, 32'h7FFFFFFF, 32'h1, 32'h0);
    op(IAB_MUL_INT, 1'b1, 32'h10000, 32'h10000, 32'h0);
    u_rf.idle();
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h00000002);
    op(IAB_ADD_CARRY, 1'b1, 32'hFFFFFFFF, 32'h0, 32'h0);
    u_rf.idle();
    op(IAB_BIT_ALTER, 1'b1, 32'h0, 32'h5, 32'h0);
    op(IAB_SUB_INT, 1'b1, 32'h80000000, 32'h1, 32'h0);
    u_rf.idle();
    apb(1'b1, 12'h000, 32'h0);
    op(IAB_BIT_ALTER, 1'b1, 32'hFFFFFFFF, 32'h5, 32'h0);
    op(IAB_SHR_ORD, 1'b1, 32'h80000001, 32'h1, 32'h0);
    op(IAB_SHR_DIV, 1'b1, 32'hFFFFFFFF, 32'h1, 32'h0);
    u_rf.idle();
    $display("Test overflow mask and alter done");
    repeat (3) @(posedge core_clk);
    chk("notes left", 0, eq.size() + aq.size());
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
